/* hw/pmq_pin_control.sv */
// Pin control for the serial, motor PWM and fault ports with register file
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pmq_pin_control (
  input  wire logic                      sys_clk,
  input  wire logic                      arst_n,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  input  wire logic [7:0]                serial_port_pins_in,
  output pmq_pkg::pmq_pad_t [7:0]        serial_port_pad,
  input  wire logic [5:0]                motor_port_pins_in,
  output pmq_pkg::pmq_pad_t [5:0]        motor_port_pad,
  input  wire logic [6:0]                fault_port_pins_in,
  output pmq_pkg::pmq_pad_t [6:0]        fault_port_pad,
  input  wire logic                      i2c_enable,
  input  wire logic                      i2c_scl_low,
  input  wire logic                      i2c_sda_low,
  output logic                           i2c_scl_in,
  output logic                           i2c_sda_in,
  input  wire logic                      serial_tx_enable,
  input  wire logic                      serial_rx_enable,
  input  wire logic                      serial_txd,
  output logic                           serial_rxd,
  input  wire logic [5:0]                pwm_channel_enable,
  input  wire logic [5:0]                pwm_channel_out,
  input  wire logic [3:0]                fault_enable,
  input  wire logic [2:0]                current_sense_enable,
  output logic      [3:0]                fault_inputs,
  output logic      [2:0]                current_sense_inputs
);

  // Synchronised pin levels
  logic [7:0] m_pin_sync;
  logic [5:0] p_pin_sync;
  logic [6:0] q_pin_sync;

  pmq_sync #(.W(8)) u_sync_m (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .async_in (serial_port_pins_in),
    .sync_out (m_pin_sync)
  );

  pmq_sync #(.W(6)) u_sync_p (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .async_in (motor_port_pins_in),
    .sync_out (p_pin_sync)
  );

  pmq_sync #(.W(7)) u_sync_q (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .async_in (fault_port_pins_in),
    .sync_out (q_pin_sync)
  );

  // Registers
  logic [7:0] m_data_latch;
  logic [7:0] m_direction_bits;
  logic [7:0] m_pull_enable_bits;
  logic [7:0] m_pull_polarity_bits;
  logic [7:0] m_open_drain_bits;
  logic [7:0] p_data_latch;
  logic [7:0] p_direction_bits;
  logic [7:0] p_reduced_drive_bits;
  logic [7:0] p_pull_enable_bits;
  logic [7:0] p_pull_polarity_bits;
  logic [7:0] q_data_latch;
  logic [7:0] q_direction_bits;

  // Write decode
  wire wr_m_data     = reg_wr && (reg_addr == pmq_pkg::A_M_DATA);
  wire wr_m_dir      = reg_wr && (reg_addr == pmq_pkg::A_M_DIR);
  wire wr_m_pull_en  = reg_wr && (reg_addr == pmq_pkg::A_M_PULL_EN);
  wire wr_m_pull_pol = reg_wr && (reg_addr == pmq_pkg::A_M_PULL_POL);
  wire wr_m_od       = reg_wr && (reg_addr == pmq_pkg::A_M_OD);
  wire wr_p_data     = reg_wr && (reg_addr == pmq_pkg::A_P_DATA);
  wire wr_p_dir      = reg_wr && (reg_addr == pmq_pkg::A_P_DIR);
  wire wr_p_rdr      = reg_wr && (reg_addr == pmq_pkg::A_P_RDR);
  wire wr_p_pull_en  = reg_wr && (reg_addr == pmq_pkg::A_P_PULL_EN);
  wire wr_p_pull_pol = reg_wr && (reg_addr == pmq_pkg::A_P_PULL_POL);
  wire wr_q_data     = reg_wr && (reg_addr == pmq_pkg::A_Q_DATA);
  wire wr_q_dir      = reg_wr && (reg_addr == pmq_pkg::A_Q_DIR);

  wire [7:0] wdata_m = reg_wdata & pmq_pkg::M_MASK;
  wire [7:0] wdata_p = reg_wdata & pmq_pkg::P_MASK;
  wire [7:0] wdata_q = reg_wdata & pmq_pkg::Q_MASK;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      m_data_latch         <= pmq_pkg::RST_M_DATA;
      m_direction_bits     <= pmq_pkg::RST_M_DIR;
      m_pull_enable_bits   <= pmq_pkg::RST_M_PULL_EN;
      m_pull_polarity_bits <= pmq_pkg::RST_M_PULL_POL;
      m_open_drain_bits    <= pmq_pkg::RST_M_OD;
    end else begin
      if (wr_m_data) m_data_latch <= wdata_m;
      if (wr_m_dir) m_direction_bits <= wdata_m;
      if (wr_m_pull_en) m_pull_enable_bits <= wdata_m;
      if (wr_m_pull_pol) m_pull_polarity_bits <= wdata_m;
      if (wr_m_od) m_open_drain_bits <= wdata_m;
    end
  end

  // Port P comes out of reset as high-impedance inputs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      p_data_latch         <= pmq_pkg::RST_P;
      p_direction_bits     <= pmq_pkg::RST_P;
      p_reduced_drive_bits <= pmq_pkg::RST_P;
      p_pull_enable_bits   <= pmq_pkg::RST_P;
      p_pull_polarity_bits <= pmq_pkg::RST_P;
    end else begin
      if (wr_p_data) p_data_latch <= wdata_p;
      if (wr_p_dir) p_direction_bits <= wdata_p;
      if (wr_p_rdr) p_reduced_drive_bits <= wdata_p;
      if (wr_p_pull_en) p_pull_enable_bits <= wdata_p;
      if (wr_p_pull_pol) p_pull_polarity_bits <= wdata_p;
    end
  end

  // Port Q comes out of reset as high-impedance inputs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q_data_latch     <= pmq_pkg::RST_Q;
      q_direction_bits <= pmq_pkg::RST_Q;
    end else begin
      if (wr_q_data) q_data_latch <= wdata_q;
      if (wr_q_dir) q_direction_bits <= wdata_q;
    end
  end

  // Read decode; pin input registers have no write path
  wire [7:0] m_pin8 = {m_pin_sync} & pmq_pkg::M_MASK;
  wire [7:0] p_pin8 = {2'b00, p_pin_sync};
  wire [7:0] q_pin8 = {1'b0, q_pin_sync};

  logic [7:0] next_rdata;

  always_comb begin
    case (reg_addr)
      pmq_pkg::A_M_DATA:
        next_rdata = pmq_pkg::pmq_port_read(m_direction_bits, m_data_latch, m_pin8);
      pmq_pkg::A_M_PIN:      next_rdata = m_pin8;
      pmq_pkg::A_M_DIR:      next_rdata = m_direction_bits;
      pmq_pkg::A_M_PULL_EN:  next_rdata = m_pull_enable_bits;
      pmq_pkg::A_M_PULL_POL: next_rdata = m_pull_polarity_bits;
      pmq_pkg::A_M_OD:       next_rdata = m_open_drain_bits;
      pmq_pkg::A_P_DATA:
        next_rdata = pmq_pkg::pmq_port_read(p_direction_bits, p_data_latch, p_pin8);
      pmq_pkg::A_P_PIN:      next_rdata = p_pin8;
      pmq_pkg::A_P_DIR:      next_rdata = p_direction_bits;
      pmq_pkg::A_P_RDR:      next_rdata = p_reduced_drive_bits;
      pmq_pkg::A_P_PULL_EN:  next_rdata = p_pull_enable_bits;
      pmq_pkg::A_P_PULL_POL: next_rdata = p_pull_polarity_bits;
      pmq_pkg::A_Q_DATA:
        next_rdata = pmq_pkg::pmq_port_read(q_direction_bits, q_data_latch, q_pin8);
      pmq_pkg::A_Q_PIN:      next_rdata = q_pin8;
      pmq_pkg::A_Q_DIR:      next_rdata = q_direction_bits;
      default:               next_rdata = pmq_pkg::RST_READ;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= pmq_pkg::RST_READ;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : pmq_pkg::RST_READ;
    end
  end

  // Port M peripheral overrides: I2C on 7:6, serial on 5:4
  logic [7:0] m_dir_eff;
  logic [7:0] m_out_eff;

  always_comb begin
    m_dir_eff = m_direction_bits & pmq_pkg::M_MASK;
    m_out_eff = m_data_latch;
    if (i2c_enable) begin
      m_dir_eff[pmq_pkg::M_SCL_BIT] = 1'b1;
      m_dir_eff[pmq_pkg::M_SDA_BIT] = 1'b1;
      m_out_eff[pmq_pkg::M_SCL_BIT] = ~i2c_scl_low;
      m_out_eff[pmq_pkg::M_SDA_BIT] = ~i2c_sda_low;
    end
    if (serial_tx_enable) begin
      m_dir_eff[pmq_pkg::M_TXD_BIT] = 1'b1;
      m_out_eff[pmq_pkg::M_TXD_BIT] = serial_txd;
    end
    if (serial_rx_enable) begin
      m_dir_eff[pmq_pkg::M_RXD_BIT] = 1'b0;
    end
  end

  // I2C lines are open drain without touching the stored bits
  wire [7:0] m_od_eff = m_open_drain_bits | (i2c_enable ? pmq_pkg::M_I2C_PINS : 8'h00);

  pmq_pad_ctl #(.W(8), .PULL_ON_OD(1'b1)) u_pad_m (
    .dir      (m_dir_eff),
    .out_val  (m_out_eff),
    .od_req   (m_od_eff),
    .pull_en  (m_pull_enable_bits),
    .pull_pol (m_pull_polarity_bits),
    .reduce   (8'h00),
    .pad      (serial_port_pad)
  );

  // Port P: an enabled PWM channel owns its pin as an output
  wire [5:0] p_dir_eff = pwm_channel_enable | p_direction_bits[5:0];
  wire [5:0] p_out_eff = (pwm_channel_enable & pwm_channel_out)
                       | (~pwm_channel_enable & p_data_latch[5:0]);

  pmq_pad_ctl #(.W(6), .PULL_ON_OD(1'b0)) u_pad_p (
    .dir      (p_dir_eff),
    .out_val  (p_out_eff),
    .od_req   (6'h00),
    .pull_en  (p_pull_enable_bits[5:0]),
    .pull_pol (p_pull_polarity_bits[5:0]),
    .reduce   (p_reduced_drive_bits[5:0]),
    .pad      (motor_port_pad)
  );

  // Port Q: enabled fault and sense functions force inputs
  wire [6:0] q_force_in = {current_sense_enable, fault_enable};
  wire [6:0] q_dir_eff  = q_direction_bits[6:0] & ~q_force_in;

  pmq_pad_ctl #(.W(7), .PULL_ON_OD(1'b0)) u_pad_q (
    .dir      (q_dir_eff),
    .out_val  (q_data_latch[6:0]),
    .od_req   (7'h00),
    .pull_en  (7'h00),
    .pull_pol (7'h00),
    .reduce   (7'h00),
    .pad      (fault_port_pad)
  );

  // Synchronised levels to the peripherals
  assign i2c_scl_in           = m_pin_sync[pmq_pkg::M_SCL_BIT];
  assign i2c_sda_in           = m_pin_sync[pmq_pkg::M_SDA_BIT];
  assign serial_rxd           = m_pin_sync[pmq_pkg::M_RXD_BIT];
  assign fault_inputs         = q_pin_sync[3:0];
  assign current_sense_inputs = q_pin_sync[6:4];

endmodule // pmq_pin_control
`default_nettype wire

/* hw/pmq_pkg.sv */
// Package with register map, reset values and pad control type for the pin control block
package pmq_pkg;

  localparam int M_W = 8;
  localparam int P_W = 6;
  localparam int Q_W = 7;
  localparam int FAULT_W = 4;
  localparam int SENSE_W = 3;
  localparam int Q_SENSE_BASE = 4;

  localparam logic [7:0] A_M_DATA     = 8'h10;
  localparam logic [7:0] A_M_PIN      = 8'h11;
  localparam logic [7:0] A_M_DIR      = 8'h12;
  localparam logic [7:0] A_M_PULL_EN  = 8'h14;
  localparam logic [7:0] A_M_PULL_POL = 8'h15;
  localparam logic [7:0] A_M_OD       = 8'h16;
  localparam logic [7:0] A_P_DATA     = 8'h18;
  localparam logic [7:0] A_P_PIN      = 8'h19;
  localparam logic [7:0] A_P_DIR      = 8'h1a;
  localparam logic [7:0] A_P_RDR      = 8'h1b;
  localparam logic [7:0] A_P_PULL_EN  = 8'h1c;
  localparam logic [7:0] A_P_PULL_POL = 8'h1d;
  localparam logic [7:0] A_Q_DATA     = 8'h20;
  localparam logic [7:0] A_Q_PIN      = 8'h21;
  localparam logic [7:0] A_Q_DIR      = 8'h22;

  localparam logic [7:0] RST_M_DATA     = 8'h00;
  localparam logic [7:0] RST_M_DIR      = 8'h00;
  localparam logic [7:0] RST_M_PULL_EN  = 8'hf0;
  localparam logic [7:0] RST_M_PULL_POL = 8'h00;
  localparam logic [7:0] RST_M_OD       = 8'h00;
  localparam logic [7:0] RST_P          = 8'h00;
  localparam logic [7:0] RST_Q          = 8'h00;
  localparam logic [7:0] RST_READ       = 8'h00;

  // Port M bit 2 has no pin behind it
  localparam logic [7:0] M_MASK = 8'hfb;
  localparam logic [7:0] P_MASK = 8'h3f;
  localparam logic [7:0] Q_MASK = 8'h7f;
  localparam logic [7:0] M_I2C_PINS = 8'hc0;

  localparam int M_SCL_BIT = 7;
  localparam int M_SDA_BIT = 6;
  localparam int M_TXD_BIT = 5;
  localparam int M_RXD_BIT = 4;

  typedef struct packed {
    logic oe;
    logic out;
    logic od;
    logic pull_en;
    logic pull_dn;
    logic reduced;
  } pmq_pad_t;

  // Data register read: latch for outputs, pin level for inputs
  function automatic logic [7:0] pmq_port_read(input logic [7:0] dir,
                                               input logic [7:0] latch,
                                               input logic [7:0] pin);
    pmq_port_read = (dir & latch) | (~dir & pin);
  endfunction

endpackage

/* hw/pmq_sync.sv */
// Two-stage synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module pmq_sync #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // pmq_sync
`default_nettype wire

/* hw/pmq_pad_ctl.sv */
// Per-pin pad control derivation for one port
`timescale 1ns/1ps
`default_nettype none
module pmq_pad_ctl #(
  parameter int W          = 8,
  parameter bit PULL_ON_OD = 1'b0
) (
  input  wire logic [W-1:0]     dir,
  input  wire logic [W-1:0]     out_val,
  input  wire logic [W-1:0]     od_req,
  input  wire logic [W-1:0]     pull_en,
  input  wire logic [W-1:0]     pull_pol,
  input  wire logic [W-1:0]     reduce,
  output pmq_pkg::pmq_pad_t [W-1:0] pad
);

  for (genvar i = 0; i < W; i++) begin : g_pin
    wire od_eff   = dir[i] & od_req[i];
    wire pull_ok  = ~dir[i] | (PULL_ON_OD & od_eff);
    // Open drain: drive only low, release when high
    assign pad[i].oe      = dir[i] & ~(od_eff & out_val[i]);
    assign pad[i].out     = out_val[i] & ~od_eff;
    assign pad[i].od      = od_eff;
    assign pad[i].pull_en = pull_ok & pull_en[i];
    assign pad[i].pull_dn = ~dir[i] & pull_en[i] & pull_pol[i];
    assign pad[i].reduced = dir[i] & reduce[i];
  end

endmodule // pmq_pad_ctl
`default_nettype wire

/* testbench/pmq_pin_control_checker.sv */
// Port-level assertions for the pin control block
`timescale 1ns/1ps
`default_nettype none
module pmq_pin_control_checker (
  input wire logic                    sys_clk,
  input wire logic                    arst_n,
  input wire logic                    reg_rd,
  input wire logic [7:0]              reg_rdata,
  input wire pmq_pkg::pmq_pad_t [7:0] serial_port_pad,
  input wire pmq_pkg::pmq_pad_t [5:0] motor_port_pad,
  input wire pmq_pkg::pmq_pad_t [6:0] fault_port_pad,
  input wire logic                    i2c_enable,
  input wire logic                    i2c_scl_low,
  input wire logic [5:0]              pwm_channel_enable,
  input wire logic [5:0]              pwm_channel_out,
  input wire logic [3:0]              fault_enable,
  input wire logic [2:0]              current_sense_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_reset_hiz: assert property (
    $rose(arst_n) |-> motor_port_pad == '0 && fault_port_pad == '0)
    else $error("port pads not high-impedance after reset");
  a_i2c_scl: assert property (
    i2c_enable |-> serial_port_pad[7].od && serial_port_pad[7].oe == i2c_scl_low
      && !serial_port_pad[7].out)
    else $error("clock pin not open-drain under i2c");
  for (genvar i = 0; i < 8; i++) begin : g_m
    a_od_no_high: assert property (serial_port_pad[i].od |-> !serial_port_pad[i].out)
      else $error("open-drain pin drives high");
    a_m_pull_push: assert property (
      serial_port_pad[i].oe && !serial_port_pad[i].od |-> !serial_port_pad[i].pull_en)
      else $error("push-pull pin has a pull");
    a_m_pol_input: assert property (
      serial_port_pad[i].pull_dn |-> !serial_port_pad[i].oe && serial_port_pad[i].pull_en)
      else $error("pull-down without input and pull");
  end
  for (genvar i = 0; i < 6; i++) begin : g_p
    a_pwm_owns: assert property (
      pwm_channel_enable[i] |-> motor_port_pad[i].oe
        && motor_port_pad[i].out == pwm_channel_out[i])
      else $error("enabled channel does not own its pin");
    a_p_pull_in: assert property (
      motor_port_pad[i].oe |-> !motor_port_pad[i].pull_en && !motor_port_pad[i].pull_dn)
      else $error("output pin has a pull");
    a_p_drive_in: assert property (!motor_port_pad[i].oe |-> !motor_port_pad[i].reduced)
      else $error("reduced drive on input pin");
  end
  for (genvar i = 0; i < 4; i++) begin : g_f
    a_q_fault_in: assert property (fault_enable[i] |-> !fault_port_pad[i].oe)
      else $error("fault pin driven");
  end
  for (genvar i = 0; i < 3; i++) begin : g_s
    a_q_sense_in: assert property (current_sense_enable[i] |-> !fault_port_pad[i+4].oe)
      else $error("sense pin driven");
  end
endmodule // pmq_pin_control_checker
bind pmq_pin_control pmq_pin_control_checker u_checker (.*);
`default_nettype wire

/* testbench/pmq_pin_model.sv */
// Package pins and the board outside them
`timescale 1ns/1ps
`default_nettype none
module pmq_pin_model #(
  parameter int W = 8
) (
  input  wire pmq_pkg::pmq_pad_t [W-1:0] pad,
  input  wire logic [W-1:0]              ext,
  output logic      [W-1:0]              level
);
  // A driven pad wins, then a pull, else the outside driver
  always_comb begin
    for (int i = 0; i < W; i++) begin
      level[i] = pad[i].oe ? pad[i].out : (pad[i].pull_en ? !pad[i].pull_dn : ext[i]);
    end
  end
endmodule // pmq_pin_model
`default_nettype wire

/* testbench/pmq_pin_control_tb.sv */
// Self-checking bench for the pin control block
`timescale 1ns/1ps
`default_nettype none
module pmq_pin_control_tb;
  localparam int OE = 5;
  localparam int OUT = 4;
  localparam int OD = 3;
  localparam int PE = 2;
  localparam int PD = 1;
  localparam int RD = 0;
  logic sys_clk, arst_n, reg_wr, reg_rd, i2c_enable, i2c_scl_low, i2c_sda_low;
  logic i2c_scl_in, i2c_sda_in, serial_tx_enable, serial_rx_enable, serial_txd, serial_rxd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, serial_port_pins_in;
  logic [5:0] motor_port_pins_in, pwm_channel_enable, pwm_channel_out;
  logic [6:0] fault_port_pins_in;
  logic [3:0] fault_enable, fault_inputs;
  logic [2:0] current_sense_enable, current_sense_inputs;
  pmq_pkg::pmq_pad_t [7:0] serial_port_pad;
  pmq_pkg::pmq_pad_t [5:0] motor_port_pad;
  pmq_pkg::pmq_pad_t [6:0] fault_port_pad;
  logic [7:0] m_ext;
  logic [5:0] p_ext;
  logic [6:0] q_ext;
  int bad_count;
  int check_count;
  pmq_pin_control dut (.*);
  pmq_pin_model #(.W(8)) u_m (.pad(serial_port_pad), .ext(m_ext), .level(serial_port_pins_in));
  pmq_pin_model #(.W(6)) u_p (.pad(motor_port_pad), .ext(p_ext), .level(motor_port_pins_in));
  pmq_pin_model #(.W(7)) u_q (.pad(fault_port_pad), .ext(q_ext), .level(fault_port_pins_in));
  function automatic logic [7:0] fld(input logic [47:0] v, input int pos);
    for (int i = 0; i < 8; i++) begin
      fld[i] = v[i*6+pos];
    end
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic t_reset;
    chk(8'(motor_port_pad == '0), 8'h01);
    chk(8'(fault_port_pad == '0), 8'h01);
    @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(pmq_pkg::A_P_DIR, 8'h00);
    rd(8'h30, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_p_port;
    wr(pmq_pkg::A_P_DATA, 8'h2a);
    wr(pmq_pkg::A_P_DIR, 8'h0f);
    chk(fld(48'(motor_port_pad), OE), 8'h0f);
    settle();
    rd(pmq_pkg::A_P_DATA, 8'h1a);
    wr(pmq_pkg::A_P_PIN, 8'hff);
    rd(pmq_pkg::A_P_PIN, 8'h1a);
    wr(pmq_pkg::A_P_RDR, 8'h3f);
    wr(pmq_pkg::A_P_PULL_EN, 8'h3f);
    wr(pmq_pkg::A_P_PULL_POL, 8'h15);
    chk(fld(48'(motor_port_pad), RD), 8'h0f);
    chk(fld(48'(motor_port_pad), PE), 8'h30);
    chk(fld(48'(motor_port_pad), PD), 8'h10);
    settle();
    rd(pmq_pkg::A_P_PIN, 8'h2a);
    $display("port p test done");
  endtask
  task automatic t_pwm;
    @(posedge sys_clk);
    pwm_channel_out <= 6'h2d;
    pwm_channel_enable <= 6'h3f;
    #1;
    chk(fld(48'(motor_port_pad), OE), 8'h3f);
    chk(fld(48'(motor_port_pad), OUT), 8'h2d);
    rd(pmq_pkg::A_P_DIR, 8'h0f);
    @(posedge sys_clk);
    pwm_channel_enable <= 6'h00;
    #1;
    chk(fld(48'(motor_port_pad), OE), 8'h0f);
    $display("pwm test done");
  endtask
  task automatic t_m_port;
    wr(pmq_pkg::A_M_DATA, 8'h20);
    wr(pmq_pkg::A_M_DIR, 8'h3b);
    wr(pmq_pkg::A_M_OD, 8'h70);
    wr(pmq_pkg::A_M_PULL_EN, 8'hf8);
    wr(pmq_pkg::A_M_PULL_POL, 8'hc8);
    chk(fld(48'(serial_port_pad), OE), 8'h1b);
    chk(fld(48'(serial_port_pad), OUT), 8'h00);
    chk(fld(48'(serial_port_pad), OD), 8'h30);
    chk(fld(48'(serial_port_pad), PE), 8'hf0);
    chk(fld(48'(serial_port_pad), PD), 8'hc0);
    $display("port m test done");
  endtask
  task automatic t_periph;
    @(posedge sys_clk);
    serial_tx_enable <= 1'b1;
    serial_rx_enable <= 1'b1;
    serial_txd <= 1'b1;
    #1;
    chk(fld(48'(serial_port_pad), OE) & 8'h20, 8'h00);
    @(posedge sys_clk);
    serial_txd <= 1'b0;
    i2c_enable <= 1'b1;
    i2c_scl_low <= 1'b1;
    #1;
    chk(fld(48'(serial_port_pad), OE) & 8'he0, 8'ha0);
    chk(fld(48'(serial_port_pad), OD) & 8'hc0, 8'hc0);
    rd(pmq_pkg::A_M_OD, 8'h70);
    settle();
    chk({6'h0, i2c_scl_in, i2c_sda_in}, 8'h01);
    chk({7'h0, serial_rxd}, 8'h01);
    $display("peripheral test done");
  endtask
  task automatic t_q_port;
    wr(pmq_pkg::A_Q_DIR, 8'h7f);
    wr(pmq_pkg::A_Q_DATA, 8'h55);
    @(posedge sys_clk);
    fault_enable <= 4'hf;
    current_sense_enable <= 3'h7;
    #1;
    chk(fld(48'(fault_port_pad), OE), 8'h00);
    settle();
    chk({1'b0, current_sense_inputs, fault_inputs}, 8'h2a);
    @(posedge sys_clk);
    q_ext <= 7'h15;
    settle();
    chk({1'b0, current_sense_inputs, fault_inputs}, 8'h15);
    rd(pmq_pkg::A_Q_DATA, 8'h55);
    @(posedge sys_clk);
    fault_enable <= 4'h0;
    #1;
    chk(fld(48'(fault_port_pad), OE), 8'h0f);
    $display("port q test done");
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {arst_n, reg_wr, reg_rd, i2c_enable, i2c_scl_low, i2c_sda_low} = '0;
    {serial_tx_enable, serial_rx_enable, serial_txd, reg_addr, reg_wdata} = '0;
    {pwm_channel_enable, pwm_channel_out, fault_enable, current_sense_enable} = '0;
    {m_ext, p_ext, q_ext} = {8'h00, 6'h15, 7'h2a};
    bad_count = 0;
    check_count = 0;
    repeat (5) @(posedge sys_clk);
    #1;
    t_reset();
    t_p_port();
    t_pwm();
    t_m_port();
    t_periph();
    t_q_port();
    conclude();
  end
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule // pmq_pin_control_tb
`default_nettype wire
